// ==== result_window_pkg.sv ====
// Purpose: Constants for the result and window comparator register block
// Assumes: Byte-wide register port, 50 MHz clock
// Notes: Flag, temp and value addresses and mode codes are local choices
`default_nettype none
package result_window_pkg;
	localparam logic [7:0] value_lo_addr = 8'h10;
	localparam logic [7:0] value_hi_addr = 8'h11;
	localparam logic [7:0] winlo_lo_addr = 8'h12;
	localparam logic [7:0] winlo_hi_addr = 8'h13;
	localparam logic [7:0] winhi_lo_addr = 8'h14;
	localparam logic [7:0] winhi_hi_addr = 8'h15;
	localparam logic [7:0] duty_cfg_addr = 8'h16;
	localparam logic [7:0] flags_addr = 8'h0b;
	localparam logic [7:0] temp_addr = 8'h0d;
	localparam logic [2:0] duty_cfg_reset = 3'h1;
	localparam int match_bit = 1;
	localparam int done_bit = 0;
	localparam logic [9:0] sample_max = 10'h3ff;
	localparam logic [9:0] sample_min = 10'h000;
	localparam logic [2:0] wmode_none = 3'h0;
	localparam logic [2:0] wmode_below = 3'h1;
	localparam logic [2:0] wmode_above = 3'h2;
	localparam logic [2:0] wmode_inside = 3'h3;
	localparam logic [2:0] wmode_outside = 3'h4;
	localparam int duty_div_default = 4;
endpackage
`default_nettype wire

// ==== duty_clock_gen.sv ====
// Purpose: Converter clock with selectable duty
// Assumes: Period of divider cycles, multiple of four
// Notes: Quarter duty keeps sampling time short at low rates
`timescale 1ns/1ps
`default_nettype none
module duty_clock_gen #(
	parameter int period = 4
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic quarter_sel,
	// Clock out
	output logic conv_clk
);
	// The quarter and half phases need whole cycles, so refuse other periods
	if (period < 4 || (period % 4) != 0) begin : g_bad_period
		$error("period must be multiple of 4");
	end
	localparam int cw = $clog2(period);
	logic [cw-1:0] cnt_ff, nxt_cnt;
	logic clk_ff, nxt_clk;
	always_comb begin
		nxt_cnt = (cnt_ff == cw'(period - 1)) ? '0 : cnt_ff + 1'b1;
		if (quarter_sel)
			nxt_clk = nxt_cnt < cw'(period / 4);
		else
			nxt_clk = nxt_cnt < cw'(period / 2);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= '0;
			clk_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			clk_ff <= nxt_clk;
		end
	end
	assign conv_clk = clk_ff;
endmodule
`default_nettype wire

// ==== result_window_regs.sv ====
// Purpose: Conversion value, window limits, duty config and flags
// Assumes: Byte register port, read data one cycle after strobe
// Notes: 16-bit values pass through the shared temp byte
`timescale 1ns/1ps
`default_nettype none
module result_window_regs import result_window_pkg::*; #(
	parameter int duty_div = duty_div_default
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Converter side
	input wire logic conv_done,
	input wire logic accum_en,
	input wire logic [15:0] accum_value,
	input wire logic [9:0] sample_raw,
	input wire logic sample_over,
	input wire logic sample_under,
	input wire logic [2:0] window_compare_mode,
	// Status and clock
	output logic window_match_flag,
	output logic sample_done_flag,
	output logic conv_clk
);
	logic [15:0] conversion_value_ff, nxt_conversion_value;
	logic [15:0] window_low_limit_ff, nxt_window_low_limit;
	logic [15:0] window_high_limit_ff, nxt_window_high_limit;
	logic [2:0] clock_duty_config_ff, nxt_clock_duty_config;
	logic [7:0] temp_ff, nxt_temp;
	logic match_ff, nxt_match, done_ff, nxt_done;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [9:0] sample_sat;
	logic [15:0] new_value;
	logic hit;

	always_comb begin
		if (sample_over)
			sample_sat = sample_max;
		else if (sample_under)
			sample_sat = sample_min;
		else
			sample_sat = sample_raw;
		// With accum_en the final sum is compared; otherwise the saturated sample reaches the compare
		new_value = accum_en ? accum_value : {6'h00, sample_sat};
		case (window_compare_mode)
			wmode_below: hit = new_value < window_low_limit_ff;
			wmode_above: hit = new_value > window_high_limit_ff;
			wmode_inside: hit = (new_value >= window_low_limit_ff) &&
				(new_value <= window_high_limit_ff);
			wmode_outside: hit = (new_value < window_low_limit_ff) ||
				(new_value > window_high_limit_ff);
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		nxt_conversion_value = conversion_value_ff;
		nxt_window_low_limit = window_low_limit_ff;
		nxt_window_high_limit = window_high_limit_ff;
		nxt_clock_duty_config = clock_duty_config_ff;
		nxt_temp = temp_ff;
		nxt_match = match_ff;
		nxt_done = done_ff;
		nxt_rdata = 8'h00;
		if (rd) begin
			case (addr)
				value_lo_addr: begin
					nxt_rdata = conversion_value_ff[7:0];
					nxt_temp = conversion_value_ff[15:8];
					nxt_match = 1'b0;
					nxt_done = 1'b0;
				end
				value_hi_addr: nxt_rdata = temp_ff;
				winlo_lo_addr: begin
					nxt_rdata = window_low_limit_ff[7:0];
					nxt_temp = window_low_limit_ff[15:8];
				end
				winlo_hi_addr: nxt_rdata = temp_ff;
				winhi_lo_addr: begin
					nxt_rdata = window_high_limit_ff[7:0];
					nxt_temp = window_high_limit_ff[15:8];
				end
				winhi_hi_addr: nxt_rdata = temp_ff;
				duty_cfg_addr: nxt_rdata = {5'h00, clock_duty_config_ff};
				flags_addr: nxt_rdata = {6'h00, match_ff, done_ff};
				temp_addr: nxt_rdata = temp_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
		if (wr) begin
			case (addr)
				winlo_lo_addr: nxt_temp = wdata;
				winlo_hi_addr: nxt_window_low_limit = {wdata, temp_ff};
				winhi_lo_addr: nxt_temp = wdata;
				winhi_hi_addr: nxt_window_high_limit = {wdata, temp_ff};
				duty_cfg_addr: nxt_clock_duty_config = wdata[2:0];
				flags_addr: begin
					if (wdata[match_bit])
						nxt_match = 1'b0;
					if (wdata[done_bit])
						nxt_done = 1'b0;
				end
				temp_addr: nxt_temp = wdata;
				default: ;
			endcase
		end
		// Set beats a clear in the same cycle
		if (conv_done) begin
			nxt_conversion_value = new_value;
			nxt_done = 1'b1;
			if (hit)
				nxt_match = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			conversion_value_ff <= 16'h0000;
			window_low_limit_ff <= 16'h0000;
			window_high_limit_ff <= 16'h0000;
			clock_duty_config_ff <= duty_cfg_reset;
			temp_ff <= 8'h00;
			match_ff <= 1'b0;
			done_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			conversion_value_ff <= nxt_conversion_value;
			window_low_limit_ff <= nxt_window_low_limit;
			window_high_limit_ff <= nxt_window_high_limit;
			clock_duty_config_ff <= nxt_clock_duty_config;
			temp_ff <= nxt_temp;
			match_ff <= nxt_match;
			done_ff <= nxt_done;
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata = rdata_ff;
	assign window_match_flag = match_ff;
	assign sample_done_flag = done_ff;

	duty_clock_gen #(
		.period(duty_div)
	) u_duty (
		.clk(clk),
		.rst(rst),
		.quarter_sel(clock_duty_config_ff[0]),
		.conv_clk(conv_clk)
	);
endmodule
`default_nettype wire

// ==== result_window_assertions.sv ====
// Purpose: Port checks for result_window_regs
// Assumes: duty_div left at four
// Notes: A conversion beats a same-cycle flag clear
`timescale 1ns/1ps
`default_nettype none
module result_window_assertions (
	// System
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// Converter
	input wire logic conv_done,
	input wire logic [2:0] window_compare_mode,
	input wire logic window_match_flag,
	input wire logic sample_done_flag,
	input wire logic conv_clk
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_value_rd;
		rd && addr == 8'h10 && !conv_done;
	endsequence
	sequence s_clear;
		!sample_done_flag && !window_match_flag;
	endsequence
	property p_done; conv_done |=> sample_done_flag; endproperty
	a_done: assert property (p_done) else $error("done flag missing");
	property p_clr; s_value_rd |=> s_clear; endproperty
	a_clr: assert property (p_clr) else $error("flags kept");
	property p_w0; wr && addr == 8'h0b && wdata == 8'h00 && sample_done_flag |=> sample_done_flag;
	endproperty
	a_w0: assert property (p_w0) else $error("zero write cleared");
	property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_none; conv_done && window_compare_mode == 3'h0 && !window_match_flag
		|=> !window_match_flag; endproperty
	a_none: assert property (p_none) else $error("match in mode none");
	property p_hold; window_match_flag && !rd && !wr |=> window_match_flag; endproperty
	a_hold: assert property (p_hold) else $error("match lost");
	// Both duty settings give at most two high and at least two low cycles
	property p_hi; $rose(conv_clk) |=> ##[0:1] !conv_clk; endproperty
	a_hi: assert property (p_hi) else $error("clock high too long");
	property p_lo; $fell(conv_clk) |=> !conv_clk; endproperty
	a_lo: assert property (p_lo) else $error("clock low too short");
endmodule
`default_nettype wire

// ==== test_result_window_regs.sv ====
// Purpose: Register and conversion tests for result_window_regs
// Assumes: duty_div left at its default
// Notes: Each case reads the result, so flags start clear
`timescale 1ns/1ps
`default_nettype none
module test_result_window_regs;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, conv_done = 1'b0;
	logic accum_en = 1'b0, sample_over = 1'b0, sample_under = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [15:0] accum_value = 16'h0000;
	logic [9:0] sample_raw = 10'h000;
	logic [2:0] window_compare_mode = 3'h0;
	logic window_match_flag, sample_done_flag, conv_clk;
	int miscompares = 0, n_tests = 0, cyc = 0;
	result_window_regs i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .conv_done(conv_done), .accum_en(accum_en),
		.accum_value(accum_value), .sample_raw(sample_raw), .sample_over(sample_over),
		.sample_under(sample_under), .window_compare_mode(window_compare_mode),
		.window_match_flag(window_match_flag), .sample_done_flag(sample_done_flag),
		.conv_clk(conv_clk));
	initial forever #10 clk = ~clk;
	task print_verdict;
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			miscompares++;
			print_verdict;
		end
	end
	task chk(input logic [7:0] s, e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	task wb(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rb(input logic [7:0] a, e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task duty_chk(input logic [7:0] e);
		logic [7:0] n;
		n = 8'h00;
		repeat (result_window_pkg::duty_div_default) begin
			@(posedge clk);
			#1 n = n + {7'h00, conv_clk};
		end
		chk(n, e);
	endtask
	task go(input logic en, input logic [15:0] av, input logic [9:0] r, input logic o, u,
		input logic [2:0] m);
		@(posedge clk);
		{accum_en, accum_value, sample_raw, sample_over, sample_under} <= {en, av, r, o, u};
		window_compare_mode <= m;
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
	endtask
	task cv(input logic en, input logic [15:0] av, input logic [9:0] r, input logic o, u,
		input logic [2:0] m, input logic [15:0] ev, input logic [7:0] f);
		go(en, av, r, o, u, m);
		rb(8'h0b, f);
		rb(8'h10, ev[7:0]);
		rb(8'h11, ev[15:8]);
		rb(8'h0b, 8'h00);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int a = 8'h12; a < 8'h17; a++) rb(8'(a), (a == 8'h16) ? 8'h01 : 8'h00);
		duty_chk(8'h01);
		rb(8'h20, 8'h00);
		wb(8'h12, 8'h34);
		wb(8'h13, 8'h12);
		wb(8'h14, 8'hff);
		wb(8'h15, 8'h56);
		rb(8'h12, 8'h34);
		rb(8'h13, 8'h12);
		rb(8'h14, 8'hff);
		rb(8'h15, 8'h56);
		wb(8'h0d, 8'ha5);
		rb(8'h0d, 8'ha5);
		wb(8'h15, 8'h56);
		rb(8'h14, 8'ha5);
		// Converter clock runs well above the low-rate limit, so half duty is picked
		wb(8'h16, 8'h06);
		rb(8'h16, 8'h06);
		duty_chk(8'h02);
		wb(8'h10, 8'hff);
		rb(8'h10, 8'h00);
		cv(1'b1, 16'h3000, 10'h000, 1'b0, 1'b0, 3'h3, 16'h3000, 8'h03);
		cv(1'b1, 16'h1234, 10'h000, 1'b0, 1'b0, 3'h3, 16'h1234, 8'h03);
		cv(1'b1, 16'h1233, 10'h000, 1'b0, 1'b0, 3'h3, 16'h1233, 8'h01);
		cv(1'b1, 16'h9000, 10'h3ff, 1'b0, 1'b0, 3'h2, 16'h9000, 8'h03);
		cv(1'b0, 16'h0001, 10'h005, 1'b1, 1'b0, 3'h1, 16'h03ff, 8'h03);
		cv(1'b0, 16'hffff, 10'h3aa, 1'b0, 1'b1, 3'h0, 16'h0000, 8'h01);
		cv(1'b0, 16'h0001, 10'h2aa, 1'b0, 1'b0, 3'h4, 16'h02aa, 8'h03);
		go(1'b1, 16'h3000, 10'h000, 1'b0, 1'b0, 3'h3);
		wb(8'h0b, 8'h00);
		rb(8'h0b, 8'h03);
		wb(8'h0b, 8'h02);
		rb(8'h0b, 8'h01);
		wb(8'h0b, 8'h01);
		rb(8'h0b, 8'h00);
		go(1'b1, 16'h3000, 10'h000, 1'b0, 1'b0, 3'h3);
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int a = 8'h12; a < 8'h17; a++) rb(8'(a), (a == 8'h16) ? 8'h01 : 8'h00);
		rb(8'h0b, 8'h00);
		duty_chk(8'h01);
		print_verdict;
	end
endmodule
bind result_window_regs result_window_assertions i_chk (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_done(conv_done),
	.window_compare_mode(window_compare_mode), .window_match_flag(window_match_flag),
	.sample_done_flag(sample_done_flag), .conv_clk(conv_clk));
`default_nettype wire
